//--- hdl/awm_pkg.sv
// awm_pkg: shared constants and types of the aux word mapper
package awm_pkg;

    localparam int          DATA_W       = 32;
    localparam int          LANES        = 4;
    localparam int          BYTE_W       = 8;
    localparam int          SEQ_W        = 6;
    localparam int          CNT_W        = 8;
    localparam int          LAT_EXTRA    = 0;

    localparam logic [5:0]  SEQ_LAST_0614 = 6'h03;
    localparam logic [5:0]  SEQ_LAST_1228 = 6'h07;
    localparam logic [5:0]  SEQ_LAST_2457 = 6'h0f;
    localparam logic [5:0]  SEQ_LAST_6144 = 6'h27;

    localparam logic [5:0]  SEQ_CW_FULL_6144 = 6'h01;
    localparam logic [5:0]  SEQ_CW_PART_6144 = 6'h02;

    localparam logic [3:0]  LANES_NONE   = 4'h0;
    localparam logic [3:0]  LANES_TOP1   = 4'h8;
    localparam logic [3:0]  LANES_TOP2   = 4'hc;
    localparam logic [3:0]  LANES_ALL    = 4'hf;

    localparam logic [7:0]  X_LAST       = 8'hff;
    localparam logic [7:0]  Z_LAST       = 8'h95;
    localparam logic [7:0]  SYNC_CHAR    = 8'hbc;
    localparam logic [3:0]  L1_PAD       = 4'h0;

    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

    typedef enum logic [1:0] {
        AWM_RATE_0614,
        AWM_RATE_1228,
        AWM_RATE_2457,
        AWM_RATE_6144
    } awm_rate_t;

endpackage : awm_pkg

//--- hdl/awm_if.sv
// awm_if: transmit aux and direct link between mapper and user logic
interface awm_if;
    logic [5:0]  tx_seq;
    logic [3:0]  tx_ctrl;
    logic        tx_err;
    logic [31:0] tx_data;
    logic [31:0] tx_mask;
    logic        dir_ready;
    logic        dir_valid;
    logic [31:0] dir_data;

    modport device (
        output tx_seq,
        output tx_ctrl,
        output tx_err,
        output dir_ready,
        input  tx_data,
        input  tx_mask,
        input  dir_valid,
        input  dir_data
    );

    modport user (
        input  tx_seq,
        input  tx_ctrl,
        input  tx_err,
        input  dir_ready,
        output tx_data,
        output tx_mask,
        output dir_valid,
        output dir_data
    );
endinterface : awm_if

//--- hdl/awm_user.sv
// awm_user: user logic end that writes aux and direct data at latency
module awm_user #(
    parameter int LAT_EXTRA = awm_pkg::LAT_EXTRA
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    awm_if.user              link,
    input  wire logic [31:0] i_aux_data,
    input  wire logic        i_aux_en,
    input  wire logic [31:0] i_dir_data,
    input  wire logic        i_dir_en,
    output logic             o_err
);

    localparam int L = LAT_EXTRA + 1;

    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        dvalid;
        logic [31:0] ddata;
    } awm_ustage_t;

    awm_ustage_t stage [0:L];
    logic [31:0] ctrl_bits;

    // control lanes widened to bits; aux never writes them
    genvar g;
    generate
        for (g = 0; g < awm_pkg::LANES; g++) begin : g_lane
            assign ctrl_bits[g*8 +: 8] = {8{link.tx_ctrl[g]}};
        end
    endgenerate

    // first byte sent sits in bits 31:24 of i_aux_data
    assign stage[0].data   = i_aux_data;
    assign stage[0].mask   = i_aux_en ? ~ctrl_bits : awm_pkg::WORD_ZERO;
    assign stage[0].dvalid = i_dir_en & link.dir_ready;
    assign stage[0].ddata  = i_dir_data;

    // one register per latency cycle, sized from the same setting
    generate
        for (g = 1; g <= L; g++) begin : g_pipe
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    stage[g] <= '0;
                end else begin
                    stage[g] <= stage[g-1];
                end
            end
        end
    endgenerate

    // word for seq n leaves exactly 1+N cycles later
    assign link.tx_data   = stage[L].data;
    assign link.tx_mask   = stage[L].mask;
    assign link.dir_valid = stage[L].dvalid;
    assign link.dir_data  = stage[L].ddata;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_err <= 1'b0;
        end else begin
            o_err <= link.tx_err;
        end
    end

endmodule : awm_user

//--- hdl/awm_device.sv
// awm_device: transmit aux and direct word mapper of the link core
module awm_device #(
    parameter int         LAT_EXTRA = awm_pkg::LAT_EXTRA,
    parameter logic [7:0] X_LAST    = awm_pkg::X_LAST,
    parameter logic [7:0] Z_LAST    = awm_pkg::Z_LAST
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    awm_if.device                  link,
    input  wire awm_pkg::awm_rate_t i_rate,
    input  wire logic              i_l1_reset_req,
    input  wire logic              i_l1_rai,
    input  wire logic              i_l1_sdi,
    input  wire logic              i_l1_los,
    output logic [31:0]            o_line_word,
    output logic [5:0]             o_line_seq,
    output logic                   o_line_sync
);

    localparam int L = LAT_EXTRA + 1;

    typedef struct packed {
        logic       special;
        logic       drdy;
        logic [3:0] ctrl;
        logic [5:0] seq;
    } awm_dstage_t;

    // last sequence slot of a basic frame for each rate
    function automatic logic [5:0] seq_last(input awm_pkg::awm_rate_t r);
        logic [5:0] v;
        v = awm_pkg::SEQ_LAST_0614;
        unique case (r)
            awm_pkg::AWM_RATE_0614: v = awm_pkg::SEQ_LAST_0614;
            awm_pkg::AWM_RATE_1228: v = awm_pkg::SEQ_LAST_1228;
            awm_pkg::AWM_RATE_2457: v = awm_pkg::SEQ_LAST_2457;
            awm_pkg::AWM_RATE_6144: v = awm_pkg::SEQ_LAST_6144;
        endcase
        return v;
    endfunction : seq_last

    // lanes of a bus word that hold the control word
    function automatic logic [3:0] ctrl_lanes(
        input awm_pkg::awm_rate_t r,
        input logic [5:0]         s
    );
        logic [3:0] v;
        v = awm_pkg::LANES_NONE;
        unique case (r)
            // one byte, top lane of word 0 only
            awm_pkg::AWM_RATE_0614: begin
                if (s == '0) begin
                    v = awm_pkg::LANES_TOP1;
                end
            end
            // two bytes, top two lanes of word 0 only
            awm_pkg::AWM_RATE_1228: begin
                if (s == '0) begin
                    v = awm_pkg::LANES_TOP2;
                end
            end
            // four bytes of one word
            awm_pkg::AWM_RATE_2457: begin
                if (s == '0) begin
                    v = awm_pkg::LANES_ALL;
                end
            end
            // ten control bytes span slots 0, 1 and top half of 2
            awm_pkg::AWM_RATE_6144: begin
                if (s <= awm_pkg::SEQ_CW_FULL_6144) begin
                    v = awm_pkg::LANES_ALL;
                end else if (s == awm_pkg::SEQ_CW_PART_6144) begin
                    v = awm_pkg::LANES_TOP2;
                end
            end
        endcase
        return v;
    endfunction : ctrl_lanes

    logic [5:0]  seq;
    logic [7:0]  x_cnt;
    logic [7:0]  z_cnt;
    logic [3:0]  ctrl;
    logic        special;
    logic        drdy;
    logic        err;

    wire  [5:0]  last_w     = seq_last(i_rate);
    wire         seq_wrap   = (seq == last_w);
    wire         x_wrap     = (x_cnt == X_LAST);
    wire  [5:0]  next_seq   = seq_wrap ? 6'h00 : seq + 6'h01;
    wire  [7:0]  next_x     = !seq_wrap ? x_cnt :
                              (x_wrap ? 8'h00 : x_cnt + 8'h01);
    wire  [7:0]  next_z     = !(seq_wrap && x_wrap) ? z_cnt :
                              ((z_cnt == Z_LAST) ? 8'h00 : z_cnt + 8'h01);
    wire  [3:0]  next_ctrl  = ctrl_lanes(i_rate, next_seq);
    // sync character goes out in the top lane when Z=X=0 in slot 0
    wire         next_spec  = (next_seq == 6'h00) && (next_x == 8'h00) &&
                              (next_z == 8'h00);
    // direct sources are asked for input only on pure data slots
    wire         next_drdy  = (next_ctrl == awm_pkg::LANES_NONE);

    // frame position counters
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            seq     <= 6'h00;
            x_cnt   <= 8'h00;
            z_cnt   <= 8'h00;
            ctrl    <= awm_pkg::LANES_ALL;
            special <= 1'b1;
            drdy    <= 1'b0;
        end else begin
            seq     <= next_seq;
            x_cnt   <= next_x;
            z_cnt   <= next_z;
            ctrl    <= next_ctrl;
            special <= next_spec;
            drdy    <= next_drdy;
        end
    end

    assign link.tx_seq    = seq;
    assign link.tx_ctrl   = ctrl;
    assign link.dir_ready = drdy;
    assign link.tx_err    = err;

    // slot attributes follow the shown seq by 1+N cycles
    awm_dstage_t stage [0:L];
    assign stage[0] = '{special: special, drdy: drdy, ctrl: ctrl, seq: seq};

    genvar g;
    generate
        for (g = 1; g <= L; g++) begin : g_pipe
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    stage[g] <= '0;
                end else begin
                    stage[g] <= stage[g-1];
                end
            end
        end
    endgenerate

    // layer1 status travels as single bits in the control byte
    wire  [7:0]  l1_byte = {awm_pkg::L1_PAD, i_l1_reset_req, i_l1_rai,
                            i_l1_sdi, i_l1_los};

    // own fill of each lane: sync char, control byte or zero
    logic [31:0] fill;
    generate
        for (g = 0; g < awm_pkg::LANES; g++) begin : g_fill
            assign fill[g*8 +: 8] =
                (stage[L].special && g == awm_pkg::LANES - 1) ?
                    awm_pkg::SYNC_CHAR :
                (stage[L].ctrl[g] ? l1_byte : 8'h00);
        end
    endgenerate

    // direct data replaces fill when ready was given for this slot
    wire  [31:0] base_word = (stage[L].drdy && link.dir_valid) ?
                             link.dir_data : fill;
    // mask bit wins over every other source
    wire  [31:0] next_word = (link.tx_mask & link.tx_data) |
                             (~link.tx_mask & base_word);
    wire         next_err  = stage[L].special && (|link.tx_mask);

    // outgoing word and error, one cycle after the write
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_line_word <= awm_pkg::WORD_ZERO;
            o_line_seq  <= 6'h00;
            o_line_sync <= 1'b0;
            err         <= 1'b0;
        end else begin
            o_line_word <= next_word;
            o_line_seq  <= stage[L].seq;
            o_line_sync <= stage[L].special;
            err         <= next_err;
        end
    end

endmodule : awm_device

//--- testbench/awm_checker.sv
// awm_checker: assertions on the link between mapper and user logic
module awm_checker #(
    parameter int LAT_EXTRA = 0
) (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [5:0]  tx_seq,
    input wire logic [3:0]  tx_ctrl,
    input wire logic        tx_err,
    input wire logic [31:0] tx_data,
    input wire logic [31:0] tx_mask,
    input wire logic        dir_ready,
    input wire logic        dir_valid,
    input wire logic [31:0] dir_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]  sq [LAT_EXTRA:0];
    logic [3:0]  cq [LAT_EXTRA:0];
    logic        rq [LAT_EXTRA:0];
    wire  [31:0] cbits;
    // slot info delayed to the cycle its data stands
    assign cbits = {{8{cq[LAT_EXTRA][3]}}, {8{cq[LAT_EXTRA][2]}},
                    {8{cq[LAT_EXTRA][1]}}, {8{cq[LAT_EXTRA][0]}}};
    always_ff @(posedge i_clk) begin
        sq[0] <= tx_seq;
        cq[0] <= tx_ctrl;
        rq[0] <= dir_ready;
        for (int k = 1; k <= LAT_EXTRA; k++) begin
            sq[k] <= sq[k-1];
            cq[k] <= cq[k-1];
            rq[k] <= rq[k-1];
        end
    end
    default clocking cb_clk @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    a_reset_state: assert property ($rose(i_rst_n) |->
        tx_seq == 6'h00 && tx_ctrl == 4'hf && !dir_ready && !tx_err)
        else $error("link not at reset state");
    a_seq_step: assert property (tx_seq == 6'h00 ||
        tx_seq == $past(tx_seq) + 6'h01) else $error("seq skipped");
    a_seq_bound: assert property (tx_seq <= 6'h27)
        else $error("seq above maximum");
    a_ctrl_early: assert property (tx_ctrl != 4'h0 |-> tx_seq <= 6'h02)
        else $error("control lanes late in frame");
    a_ready_data: assert property (dir_ready |-> tx_ctrl == 4'h0)
        else $error("ready on control slot");
    a_valid_lat: assert property (dir_valid |-> rq[LAT_EXTRA])
        else $error("direct word off latency");
    a_mask_ctrl: assert property ((tx_mask & cbits) == 32'h0)
        else $error("mask over control lanes");
    a_err_cause: assert property (tx_err |-> $past(tx_mask) != 32'h0
        && $past(sq[LAT_EXTRA]) == 6'h00) else $error("error without cause");
    c_err: cover property (tx_err);
    c_dir: cover property (dir_valid && dir_data != 32'h0);
    c_ones: cover property (tx_mask != 32'h0 && tx_data == 32'hffff_ffff);
endmodule : awm_checker

//--- testbench/aux_tx_latency_word_mapper_tb.sv
// aux_tx_latency_word_mapper_tb: bench driving both user sides
module aux_tx_latency_word_mapper_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 2;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] d;
        logic        ae;
        logic        de;
    } awm_in_t;
    logic               i_clk;
    logic               i_rst_n;
    awm_pkg::awm_rate_t rate;
    logic [3:0]         l1;
    awm_in_t            cur;
    awm_in_t            q[$];
    logic [31:0]        word;
    logic [5:0]         seq;
    logic               sync;
    logic               err;
    int                 n_errors;
    int                 checks;
    int                 cyc;
    awm_if link();
    awm_device #(.LAT_EXTRA(LAT), .X_LAST(8'h01), .Z_LAST(8'h01)) i_awm_device (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .i_rate(rate),
        .i_l1_reset_req(l1[3]), .i_l1_rai(l1[2]), .i_l1_sdi(l1[1]),
        .i_l1_los(l1[0]), .o_line_word(word), .o_line_seq(seq),
        .o_line_sync(sync));
    awm_user #(.LAT_EXTRA(LAT)) i_awm_user (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .link(link), .i_aux_data(cur.a), .i_aux_en(cur.ae),
        .i_dir_data(cur.d), .i_dir_en(cur.de), .o_err(err));
    awm_checker #(.LAT_EXTRA(LAT)) i_awm_checker (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .tx_seq(link.tx_seq), .tx_ctrl(link.tx_ctrl),
        .tx_err(link.tx_err), .tx_data(link.tx_data), .tx_mask(link.tx_mask),
        .dir_ready(link.dir_ready), .dir_valid(link.dir_valid),
        .dir_data(link.dir_data));
    function automatic logic [3:0] lanes(logic [5:0] n);
        case (rate)
            awm_pkg::AWM_RATE_0614: return n == 6'h00 ? 4'h8 : 4'h0;
            awm_pkg::AWM_RATE_1228: return n == 6'h00 ? 4'hc : 4'h0;
            awm_pkg::AWM_RATE_2457: return n == 6'h00 ? 4'hf : 4'h0;
            default: return n < 6'h02 ? 4'hf : (n == 6'h02 ? 4'hc : 4'h0);
        endcase
    endfunction : lanes
    function automatic logic [5:0] last();
        case (rate)
            awm_pkg::AWM_RATE_0614: return 6'h03;
            awm_pkg::AWM_RATE_1228: return 6'h07;
            awm_pkg::AWM_RATE_2457: return 6'h0f;
            default: return 6'h27;
        endcase
    endfunction : last
    function automatic logic [31:0] exp_word(awm_in_t e, logic [5:0] n);
        logic [3:0]  ln;
        logic [31:0] lm;
        logic [31:0] m;
        logic [31:0] f;
        ln = lanes(n);
        lm = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
        m = e.ae ? ~lm : 32'h0000_0000;
        f = lm & {4{4'h0, l1}};
        if (sync === 1'b1) begin
            f[31:24] = 8'hbc;
        end
        f = (e.de && ln == 4'h0) ? e.d : f;
        return (e.a & m) | (f & ~m);
    endfunction : exp_word
    task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word
    task automatic cmp_flag(string nm, logic e, logic g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_flag
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic run(int r);
        awm_in_t    e;
        logic [5:0] ps;
        logic       pe;
        logic       sy;
        int         bf;
        @(posedge i_clk);
        #1;
        rate = awm_pkg::awm_rate_t'(r);
        l1 = 4'($urandom);
        cur = '0;
        i_rst_n = 1'b0;
        q.delete();
        {ps, pe, sy, bf} = '0;
        repeat (8) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        for (int s = 0; s < 400; s++) begin
            @(posedge i_clk);
            #1;
            if (s > LAT + 4) begin
                e.a[5:0] = ps == last() ? 6'h00 : ps + 6'h01;
                cmp_word("seq", {26'h0, e.a[5:0]}, {26'h0, seq});
                cmp_flag("err", pe, err);
                if (seq == 6'h00) begin
                    bf = (sy || sync !== 1'b1) ? bf + 1 : 0;
                    sy = sy || sync === 1'b1;
                end
                if (sy) cmp_flag("sync", seq == 6'h00 && bf % 4 == 0, sync);
            end
            ps = seq;
            if (q.size() == LAT + 2) begin
                e = q.pop_front();
                if (s > LAT + 4) cmp_word("word", exp_word(e, seq), word);
                pe = sync && e.ae && lanes(seq) != 4'hf;
            end
            e.a = (s % 100 < 20) ? 32'hffff_ffff : $urandom;
            e.d = $urandom;
            e.ae = (s % 100 >= 80) ? 1'b0 : 1'($urandom);
            e.de = (s % 100 >= 90) ? 1'b0 : 1'($urandom);
            cur = e;
            q.push_back(e);
        end
        $display("rate %0d done, mismatches %0d", r, n_errors);
    endtask : run
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        i_rst_n = 1'b0;
        cur = '0;
        rate = awm_pkg::AWM_RATE_0614;
        l1 = 4'h0;
        void'($urandom(16));
        for (int r = 0; r < 4; r++) begin
            run(r);
        end
        print_verdict();
    end
endmodule : aux_tx_latency_word_mapper_tb
